// ==== rtl/imls_pkg.sv ====
// Package for the interrupt mask and live status register group.
// Assumes an 8-bit register port with byte addresses from the control port.
package imls_pkg;

    // Register byte addresses
    localparam logic [7:0] IMLS_OFS_MASK_LOW = 8'h20;
    localparam logic [7:0] IMLS_OFS_MASK_HIGH = 8'h21;
    localparam logic [7:0] IMLS_OFS_LIVE_LOW = 8'h22;
    localparam logic [7:0] IMLS_OFS_LIVE_HIGH = 8'h23;

    // Reset values
    localparam logic [7:0] IMLS_RST_MASK_LOW = 8'hfc;
    localparam logic [7:0] IMLS_RST_MASK_HIGH = 8'hb1;
    localparam logic [7:0] IMLS_RST_LIVE = 8'h00;
    localparam logic IMLS_RST_IRQ = 1'b0;

    // Mask encoding
    localparam logic IMLS_NOT_MASKED = 1'b0;
    localparam logic IMLS_MASKED = 1'b1;

    // Live high register: bits that carry events, others read zero
    localparam logic [7:0] IMLS_LIVE_HIGH_USED = 8'h8f;

    // Field positions, low group
    localparam int IMLS_BIT_LIM_MUTE = 7;
    localparam int IMLS_BIT_LIM_HOLD = 6;
    localparam int IMLS_BIT_LIM_MAXATT = 5;
    localparam int IMLS_BIT_BAT_INFL = 4;
    localparam int IMLS_BIT_LIM_ACTIVE = 3;
    localparam int IMLS_BIT_TDM_CLK = 2;
    localparam int IMLS_BIT_OVER_CUR = 1;
    localparam int IMLS_BIT_OVER_TEMP = 0;

    // Field positions, high group
    localparam int IMLS_BIT_PDM_DATA = 7;
    localparam int IMLS_BIT_BAT_OVLO = 3;
    localparam int IMLS_BIT_BAT_UVLO = 2;
    localparam int IMLS_BIT_BAT_BROWN = 1;
    localparam int IMLS_BIT_PDM_CLK = 0;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } imls_req_type;

    // Register port answer
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } imls_rsp_type;

endpackage

// ==== rtl/imls_sync.sv ====
// Two-stage synchroniser for a vector of level inputs.
// Assumes inputs are levels from outside the mclk domain.
`timescale 1ns/1ps
module imls_sync
    import imls_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // imls_sync

// ==== rtl/imls_top.sv ====
// Interrupt mask and live status register group.
// Assumes a register port decoded from the control port, one access per cycle,
// and event sources as asynchronous levels, high while the condition holds.
// Operation
// RQ1: Mask bit zero reports the event, one suppresses it.
// RQ2: Low mask bits 7,6,5,3 are limiter mute, hold, max attenuation, active; reset one.
// RQ3: Low mask bit 4 battery inflection, bit 2 TDM clock error; reset one.
// RQ4: Low mask bit 1 over-current, bit 0 over-temperature; reset zero.
// RQ5: Low mask register is read/write, resets to fc.
// RQ6: High mask bit 7 PDM data invalid, resets one.
// RQ7: High mask bit 0 PDM clock error, resets one.
// RQ8: High mask bits 3,2,1 overvoltage, undervoltage, brown-out; reset zero.
// RQ9: High mask resets b1; reserved bits 6..4 writable; host writes them back.
// RQ10: Low live register read-only, resets zero, bit 7 limiter mute.
// RQ11: Live bits 6 and 5 show infinite hold and max attenuation.
// RQ12: Live bit 4 battery below inflection, bit 3 limiter active.
// RQ13: Live bits 2,1,0 show TDM clock, over-current, over-temperature.
// RQ14: High live register read-only, resets zero, bits 6..4 read zero.
// RQ15: High live bit 3 overvoltage, 2 undervoltage, 1 brown-out, 0 PDM clock.
// RQ16: Interrupt request only from unmasked active events; masked stay visible.
`timescale 1ns/1ps
module imls_top
    import imls_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire imls_req_type reg_req,
    output imls_rsp_type reg_rsp,
    // Event sources, low group
    input wire logic [7:0] event_low,
    // Event sources, high group
    input wire logic [7:0] event_high,
    // Interrupt request and masks
    output logic irq,
    output logic [7:0] mask_low_out,
    output logic [7:0] mask_high_out
);

    logic [7:0] event_low_sync;
    logic [7:0] event_high_sync;
    logic [7:0] event_mask_low;
    logic [7:0] event_mask_high;
    logic [7:0] live_event_low;
    logic [7:0] live_event_high;
    logic [7:0] next_rdata;
    logic next_irq;
    wire logic [7:0] pending_low;
    wire logic [7:0] pending_high;

    // Event inputs pass two flip-flops
    imls_sync #(.WIDTH(8)) u_sync_low
    (
        .mclk(mclk),
        .srst(srst),
        .async_in(event_low),
        .sync_out(event_low_sync)
    );

    imls_sync #(.WIDTH(8)) u_sync_high
    (
        .mclk(mclk),
        .srst(srst),
        .async_in(event_high),
        .sync_out(event_high_sync)
    );

    // Mask registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            event_mask_low <= IMLS_RST_MASK_LOW; // [RQ2] [RQ3] [RQ4] [RQ5]
            event_mask_high <= IMLS_RST_MASK_HIGH; // [RQ6] [RQ7] [RQ8] [RQ9]
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == IMLS_OFS_MASK_LOW)
            begin
                event_mask_low <= reg_req.wdata; // [RQ5]
            end
            if (reg_req.addr == IMLS_OFS_MASK_HIGH)
            begin
                event_mask_high <= reg_req.wdata; // [RQ9]
            end
        end
    end

    // Live readback follows present event state
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            live_event_low <= IMLS_RST_LIVE; // [RQ10]
            live_event_high <= IMLS_RST_LIVE; // [RQ14]
        end
        else
        begin
            live_event_low <= event_low_sync; // [RQ10] [RQ11] [RQ12] [RQ13]
            live_event_high <= event_high_sync & IMLS_LIVE_HIGH_USED; // [RQ14] [RQ15]
        end
    end

    // Read data decode; live registers ignore writes
    always_comb
    begin
        unique case (reg_req.addr)
            IMLS_OFS_MASK_LOW: next_rdata = event_mask_low;
            IMLS_OFS_MASK_HIGH: next_rdata = event_mask_high;
            IMLS_OFS_LIVE_LOW: next_rdata = live_event_low; // [RQ10]
            IMLS_OFS_LIVE_HIGH: next_rdata = live_event_high; // [RQ14]
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            reg_rsp <= '0;
        end
        else
        begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.rdata <= reg_req.rd ? next_rdata : 8'h00;
        end
    end

    // Per-source pending flag: event live and its mask bit clear
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_pending
        assign pending_low[gi] = live_event_low[gi]
            & (event_mask_low[gi] == IMLS_NOT_MASKED); // [RQ1]
        assign pending_high[gi] = live_event_high[gi] & IMLS_LIVE_HIGH_USED[gi]
            & (event_mask_high[gi] == IMLS_NOT_MASKED); // [RQ1]
    end

    // Interrupt request from unmasked events only
    always_comb
    begin
        next_irq = |{pending_high, pending_low}; // [RQ1] [RQ16]
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            irq <= IMLS_RST_IRQ;
            mask_low_out <= IMLS_RST_MASK_LOW;
            mask_high_out <= IMLS_RST_MASK_HIGH;
        end
        else
        begin
            irq <= next_irq; // [RQ16]
            mask_low_out <= event_mask_low;
            mask_high_out <= event_mask_high;
        end
    end

    // Checks
    property p_mask_low_reset;
        @(posedge mclk) srst |=> (event_mask_low == IMLS_RST_MASK_LOW);
    endproperty
    a_mask_low_reset: assert property (p_mask_low_reset) // [RQ5]
        else $error("low mask not fc after reset");

    property p_mask_high_reset;
        @(posedge mclk) srst |=> (event_mask_high == IMLS_RST_MASK_HIGH);
    endproperty
    a_mask_high_reset: assert property (p_mask_high_reset) // [RQ9]
        else $error("high mask not b1 after reset");

    property p_mask_write;
        @(posedge mclk) disable iff (srst)
        (reg_req.wr && reg_req.addr == IMLS_OFS_MASK_LOW)
            |=> (event_mask_low == $past(reg_req.wdata));
    endproperty
    a_mask_write: assert property (p_mask_write) // [RQ5]
        else $error("low mask write lost");

    property p_mask_high_write;
        @(posedge mclk) disable iff (srst)
        (reg_req.wr && reg_req.addr == IMLS_OFS_MASK_HIGH)
            |=> (event_mask_high == $past(reg_req.wdata));
    endproperty
    a_mask_high_write: assert property (p_mask_high_write) // [RQ9]
        else $error("high mask write lost");

    property p_live_low_follow;
        @(posedge mclk) disable iff (srst)
        !srst |-> ##3 (live_event_low == $past(event_low, 3));
    endproperty
    a_live_low_follow: assert property (p_live_low_follow) // [RQ13]
        else $error("low live does not follow events in three cycles");

    property p_live_high_reserved;
        @(posedge mclk) disable iff (srst)
        (live_event_high[6:4] == 3'h0);
    endproperty
    a_live_high_reserved: assert property (p_live_high_reserved) // [RQ14]
        else $error("high live reserved bits set");

    property p_masked_quiet;
        @(posedge mclk) disable iff (srst)
        ((live_event_low & ~event_mask_low) == 8'h00
            && (live_event_high & ~event_mask_high & IMLS_LIVE_HIGH_USED) == 8'h00) |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) // [RQ16]
        else $error("irq raised by masked events");

    property p_unmasked_fires;
        @(posedge mclk) disable iff (srst)
        (live_event_low[0] && !event_mask_low[0]) |=> irq;
    endproperty
    a_unmasked_fires: assert property (p_unmasked_fires) // [RQ1]
        else $error("unmasked over-temperature did not raise irq");

    property p_read_live;
        @(posedge mclk) disable iff (srst)
        (reg_req.rd && reg_req.addr == IMLS_OFS_LIVE_LOW)
            |=> (reg_rsp.valid && reg_rsp.rdata == $past(live_event_low));
    endproperty
    a_read_live: assert property (p_read_live) // [RQ10]
        else $error("live low read data wrong");

    property p_live_high_follow;
        @(posedge mclk) disable iff (srst)
        !srst |-> ##3 (live_event_high == ($past(event_high, 3) & IMLS_LIVE_HIGH_USED));
    endproperty
    a_live_high_follow: assert property (p_live_high_follow) // [RQ15]
        else $error("high live does not follow events in three cycles");

    property p_unmasked_any;
        @(posedge mclk) disable iff (srst)
        ((live_event_low & ~event_mask_low) != 8'h00
            || (live_event_high & ~event_mask_high & IMLS_LIVE_HIGH_USED) != 8'h00) |=> irq;
    endproperty
    a_unmasked_any: assert property (p_unmasked_any) // [RQ16]
        else $error("unmasked live event did not raise irq");

    property p_read_live_high;
        @(posedge mclk) disable iff (srst)
        (reg_req.rd && reg_req.addr == IMLS_OFS_LIVE_HIGH)
            |=> (reg_rsp.valid && reg_rsp.rdata == $past(live_event_high));
    endproperty
    a_read_live_high: assert property (p_read_live_high) // [RQ14]
        else $error("live high read data wrong");

    property p_read_mask_low;
        @(posedge mclk) disable iff (srst)
        (reg_req.rd && reg_req.addr == IMLS_OFS_MASK_LOW)
            |=> (reg_rsp.valid && reg_rsp.rdata == $past(event_mask_low));
    endproperty
    a_read_mask_low: assert property (p_read_mask_low) // [RQ5]
        else $error("low mask read data wrong");

    property p_read_mask_high;
        @(posedge mclk) disable iff (srst)
        (reg_req.rd && reg_req.addr == IMLS_OFS_MASK_HIGH)
            |=> (reg_rsp.valid && reg_rsp.rdata == $past(event_mask_high));
    endproperty
    a_read_mask_high: assert property (p_read_mask_high) // [RQ9]
        else $error("high mask read data wrong");

    property p_mask_low_hold;
        @(posedge mclk) disable iff (srst)
        !(reg_req.wr && reg_req.addr == IMLS_OFS_MASK_LOW) |=> $stable(event_mask_low);
    endproperty
    a_mask_low_hold: assert property (p_mask_low_hold) // [RQ5]
        else $error("low mask changed without a write");

    property p_mask_high_hold;
        @(posedge mclk) disable iff (srst)
        !(reg_req.wr && reg_req.addr == IMLS_OFS_MASK_HIGH) |=> $stable(event_mask_high);
    endproperty
    a_mask_high_hold: assert property (p_mask_high_hold) // [RQ9]
        else $error("high mask changed without a write");

    property p_live_ignores_write;
        @(posedge mclk) disable iff (srst)
        (reg_req.wr && (reg_req.addr == IMLS_OFS_LIVE_LOW || reg_req.addr == IMLS_OFS_LIVE_HIGH))
            |=> ($stable(event_mask_low) && $stable(event_mask_high));
    endproperty
    a_live_ignores_write: assert property (p_live_ignores_write) // [RQ10] [RQ14]
        else $error("write to live register changed a mask");

    property p_irq_reset;
        @(posedge mclk) srst |=> (irq == IMLS_RST_IRQ);
    endproperty
    a_irq_reset: assert property (p_irq_reset) // [RQ16]
        else $error("irq not low after reset");

    property p_live_reset;
        @(posedge mclk) srst
            |=> (live_event_low == IMLS_RST_LIVE && live_event_high == IMLS_RST_LIVE);
    endproperty
    a_live_reset: assert property (p_live_reset) // [RQ10] [RQ14]
        else $error("live registers not zero after reset");

    property p_mask_out_follow;
        @(posedge mclk) disable iff (srst)
        !srst |-> (mask_low_out == $past(event_mask_low)
            && mask_high_out == $past(event_mask_high));
    endproperty
    a_mask_out_follow: assert property (p_mask_out_follow) // [RQ5] [RQ9]
        else $error("mask outputs do not follow mask registers");

    property p_rsp_idle;
        @(posedge mclk) disable iff (srst)
        !reg_req.rd |=> (!reg_rsp.valid && reg_rsp.rdata == 8'h00);
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) // [RQ10] [RQ14]
        else $error("read answer without a read");

endmodule // imls_top

// ==== verification/imls_host_model.sv ====
// Host side of the register port: single-byte writes and reads.
// Assumes one mclk domain; requests change just after a rising edge.
`timescale 1ns/1ps
module imls_host_model
    import imls_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register port
    output imls_req_type reg_req,
    input wire imls_rsp_type reg_rsp
);
    logic [7:0] rd_data;
    logic rd_valid;

    initial reg_req = '0;

    // Released address and data show the inverse of the last values
    task automatic idle();
        reg_req <= '{1'b0, 1'b0, ~reg_req.addr, ~reg_req.wdata};
    endtask

    // Reserved high-mask bits are written back as 011 by callers, except the access-kinds write of 40
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        idle();
    endtask

    // Answer is taken one cycle after the read strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_req <= '{1'b0, 1'b1, a, reg_req.wdata};
        @(posedge mclk);
        idle();
        #1;
        rd_valid = reg_rsp.valid;
        rd_data = reg_rsp.rdata;
    endtask
endmodule // imls_host_model

// ==== verification/test_interrupt_mask_live_status.sv ====
// Testbench for the interrupt mask and live status register group.
// Assumes the host model drives the register port; bench drives events.
`timescale 1ns/1ps
module test_interrupt_mask_live_status;
    import imls_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] event_low = 8'h00;
    logic [7:0] event_high = 8'h00;
    imls_req_type reg_req;
    imls_rsp_type reg_rsp;
    logic irq;
    logic [7:0] mask_low_out;
    logic [7:0] mask_high_out;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 32'hf222;
    logic [7:0] ml, mh, el, eh;

    always #5 mclk = ~mclk;

    imls_top uut (.mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .event_low(event_low), .event_high(event_high), .irq(irq),
        .mask_low_out(mask_low_out), .mask_high_out(mask_high_out));

    imls_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rsp(reg_rsp));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read one register; the answer must arrive with valid
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a);
        check({7'h00, host.rd_valid}, 8'h01);
        check(host.rd_data, exp);
    endtask

    // Interrupt expected from unmasked events; high bits 6..4 carry none
    function automatic logic exp_irq(input logic [7:0] l, h, m0, m1);
        return (|(l & ~m0)) | (|(h & 8'h8f & ~m1));
    endfunction

    // Set events, wait past the input latency, check outputs and readback
    task automatic ev_chk(input logic [7:0] l, h, m0, m1);
        @(posedge mclk);
        event_low <= l;
        event_high <= h;
        repeat (6) @(posedge mclk);
        #1;
        check(mask_low_out, m0);
        check(mask_high_out, m1);
        check({7'h00, irq}, {7'h00, exp_irq(l, h, m0, m1)});
        rd_chk(8'h22, l);
        rd_chk(8'h23, h & 8'h8f);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk(8'h20, 8'hfc);
        rd_chk(8'h21, 8'hb1);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h23, 8'h00);
        check(mask_low_out, 8'hfc);
        check(mask_high_out, 8'hb1);
        check({7'h00, irq}, 8'h00);
        $display("Test reset values done");
        host.wr(8'h22, 8'hff);
        host.wr(8'h23, 8'hff);
        host.wr(8'h30, 8'hff);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h23, 8'h00);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h20, 8'hfc);
        rd_chk(8'h21, 8'hb1);
        host.wr(8'h21, 8'h40);
        rd_chk(8'h21, 8'h40);
        $display("Test access kinds done");
        repeat (12)
        begin
            ml = $random(seed);
            mh = ($random(seed) & 8'h8f) | 8'h30;
            el = $random(seed);
            eh = $random(seed);
            host.wr(8'h20, ml);
            host.wr(8'h21, mh);
            ev_chk(el, eh, ml, mh);
        end
        $display("Test random events done");
        host.wr(8'h20, 8'hff);
        host.wr(8'h21, 8'hbf);
        ev_chk(8'hff, 8'hff, 8'hff, 8'hbf);
        host.wr(8'h20, 8'h00);
        host.wr(8'h21, 8'h30);
        ev_chk(8'h00, 8'h01, 8'h00, 8'h30);
        ev_chk(8'h01, 8'h00, 8'h00, 8'h30);
        $display("Test mask corners done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk(8'h20, 8'hfc);
        rd_chk(8'h21, 8'hb1);
        ev_chk(8'h01, 8'h01, 8'hfc, 8'hb1);
        $display("Test mid-run reset done");
        close_out();
    end
endmodule // test_interrupt_mask_live_status
